// ### bench/i2csl_checker.sv
/*
 * i2csl_checker: port-level assertions for i2csl_top.
 * Assumes one clock and ce held high by the bench.
 */
module i2csl_checker
	import i2csl_pkg::*;
(
	input wire logic                         clk,
	input wire logic                         sys_rst,
	input wire logic [i2csl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [i2csl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                         reg_wr,
	input wire logic                         reg_rd,
	input wire logic [i2csl_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                         sda_oe,
	input wire logic                         irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [14:0] own_q;
	logic [2:0]  ien_q;
	logic        glb_q;
	logic        en_q;
	logic [1:0]  off_q;
	wire logic   wr_ctl = reg_wr && reg_addr == REG_CTRL;
	wire logic   mapped = reg_addr inside {REG_CTRL, REG_OWN_ADDR, REG_INT_EN, REG_INT_RAW,
		REG_INT_MSK, REG_INT_CLR, REG_STATUS, REG_DATA};

	// shadow copies of own address, interrupt enables and the ctrl enable and global interrupt enable bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			own_q <= OWN_RST;
			ien_q <= INT_EN_RST;
			glb_q <= 1'b0;
			en_q  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_OWN_ADDR)
				own_q <= reg_wdata[14:0];
			if (reg_wr && reg_addr == REG_INT_EN)
				ien_q <= reg_wdata[2:0];
			if (wr_ctl) begin
				glb_q <= reg_wdata[CTRL_GLB_IE_BIT];
				en_q  <= reg_wdata[CTRL_ENABLE_BIT];
			end
		end
	end

	// settle time after disable, for the registered sda_oe release to land
	always_ff @(posedge clk) begin
		if (sys_rst || en_q)
			off_q <= 2'h0;
		else if (off_q != 2'h3)
			off_q <= off_q + 2'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_rd_own;
		reg_rd && reg_addr == REG_OWN_ADDR;
	endsequence
	sequence s_rd_ien;
		reg_rd && reg_addr == REG_INT_EN;
	endsequence

	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside read");
	AST_UNMAPPED: assert property (reg_rd && !mapped |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	AST_OWN_RB: assert property (s_rd_own |=> {reg_rdata[14:8], reg_rdata[6:0]} == {own_q[14:8], own_q[6:0]})
		else $error("own address readback wrong");
	AST_IEN_RB: assert property (s_rd_ien |=> reg_rdata[2:0] == ien_q)
		else $error("enable readback wrong");
	AST_IRQ_GATE: assert property (irq |-> $past(glb_q) && $past(ien_q) != 3'h0)
		else $error("irq without enables");
	AST_EN_OFF: assert property (reg_wr && reg_addr == REG_INT_EN && reg_wdata[2:0] == 3'h0 |-> ##2 !irq [*2])
		else $error("irq after all sources disabled");
	AST_OFF_QUIET: assert property (off_q == 2'h3 |-> !sda_oe)
		else $error("sda driven while disabled");
	AST_RST_QUIET: assert property ($past(sys_rst) |-> !irq && reg_rdata == '0)
		else $error("outputs active after reset");
endmodule : i2csl_checker

bind i2csl_top i2csl_checker chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_oe(sda_oe), .irq(irq));

// ### bench/i2csl_master_model.sv
/*
 * i2csl_master_model: behavioural i2c bus master.
 * Assumes the bench resolves sda as open drain with a pull-up.
 */
module i2csl_master_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_m
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl   = 1'b1;
		sda_m = 1'b1;
	end
	// quarter bit, long enough for the input synchronisers
	task automatic q;
		repeat (10) @(posedge clk);
	endtask : q
	task automatic bit_io(input logic b, output logic r);
		sda_m <= b;
		q();
		scl <= 1'b1;
		q();
		r = sda_line;
		q();
		scl <= 1'b0;
		q();
	endtask : bit_io
	task automatic start;
		sda_m <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_m <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask : start
	task automatic stop;
		sda_m <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_m <= 1'b1;
		q();
	endtask : stop
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : wr_byte
	task automatic rd_byte(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : rd_byte
endmodule : i2csl_master_model

// ### bench/i2csl_tb_top.sv
/*
 * i2csl_tb_top: self-checking bench for i2csl_top with a bus master model.
 * Assumes ce held high and sda resolved as open drain with a pull-up.
 */
module i2csl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import i2csl_pkg::*;
	logic              clk;
	logic              sys_rst;
	logic              reg_wr;
	logic              reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic [DATA_W-1:0] v;
	logic              sda_out;
	logic              sda_oe;
	logic              irq;
	logic              scl;
	logic              sda_m;
	logic              ack;
	logic [7:0]        b;
	int                fails;
	int                tests_run;
	wire logic         sda_line = sda_m & ~(sda_oe & ~sda_out);

	i2csl_top dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	i2csl_master_model mdl_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic rc(input string n, input logic [3:0] a, input logic [31:0] e);
		rd(a, v);
		chk(n, e, v);
	endtask : rc
	task automatic ci(input logic e);
		repeat (2) @(posedge clk);
		#1 chk("irq", 32'(e), 32'(irq));
	endtask : ci

	task automatic t_reset;
		rc("ctrl", REG_CTRL, 32'(CTRL_RST));
		rc("int_en", REG_INT_EN, 32'(INT_EN_RST));
		rc("unmapped", 4'h5, 32'h0);
		rc("status", REG_STATUS, 32'(act_idle));
		wr(REG_OWN_ADDR, 32'h0000_2a3b);
		wr(REG_CTRL, 32'h0000_000f);
		rc("own", REG_OWN_ADDR, 32'h0000_2a3b);
	endtask : t_reset
	task automatic t_write;
		mdl_u.start();
		mdl_u.wr_byte(8'h22, ack);
		chk("foreign ack", 32'h0, 32'(ack));
		mdl_u.stop();
		mdl_u.start();
		mdl_u.wr_byte(8'h76, ack);
		mdl_u.wr_byte(8'hc6, ack);
		rd(REG_STATUS, v);
		chk("status wr", 32'(act_master_wrote | act_first_byte_in), v & 32'h5);
		rc("data", REG_DATA, 32'h0000_00c6);
		mdl_u.stop();
		rd(REG_STATUS, v);
		rc("status idle", REG_STATUS, 32'(act_idle));
	endtask : t_write
	task automatic t_read;
		wr(REG_DATA, 32'h0000_005a);
		mdl_u.start();
		mdl_u.wr_byte(8'h55, ack);
		chk("alt ack", 32'h1, 32'(ack));
		rd(REG_STATUS, v);
		chk("status rd", 32'(act_master_reads | act_alt_address_hit), v & 32'ha);
		mdl_u.rd_byte(b, 1'b1);
		chk("tx byte", 32'h5a, 32'(b));
		mdl_u.stop();
		wr(REG_DATA, 32'h0000_00ff);
		mdl_u.start();
		mdl_u.wr_byte(8'h77, ack);
		mdl_u.stop();
		rd(REG_STATUS, v);
		chk("status quick", 32'(act_quick_cmd | act_quick_cmd_bit_set), v & 32'h30);
		mdl_u.start();
		mdl_u.wr_byte(8'h76, ack);
		mdl_u.stop();
		rc("status quick wr", REG_STATUS, 32'(act_quick_cmd));
	endtask : t_read
	task automatic t_fifo;
		mdl_u.start();
		mdl_u.wr_byte(8'h76, ack);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			mdl_u.wr_byte(8'(i), ack);
			chk("fill ack", 32'(i < FIFO_DEPTH), 32'(ack));
		end
		mdl_u.stop();
		for (int i = 0; i < FIFO_DEPTH; i++)
			rc("drain", REG_DATA, 32'(i));
	endtask : t_fifo
	task automatic t_irq;
		rc("raw", REG_INT_RAW, 32'h7);
		wr(REG_INT_EN, 32'h3);
		ci(1'b1);
		wr(REG_CTRL, 32'hd);
		ci(1'b0);
		wr(REG_CTRL, 32'hf);
		wr(REG_INT_CLR, 32'h2);
		ci(1'b1);
		rc("raw part", REG_INT_RAW, 32'h5);
		rc("masked", REG_INT_MSK, 32'h1);
		wr(REG_INT_CLR, 32'h1);
		ci(1'b0);
		wr(REG_INT_EN, 32'h4);
		ci(1'b1);
		wr(REG_INT_EN, 32'h0);
		ci(1'b0);
	endtask : t_irq

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		sys_rst   = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = '0;
		reg_wdata = '0;
		fails     = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_write();
		t_read();
		t_fifo();
		t_irq();
		end_of_test();
	end
	// the traffic above needs about 9.5k cycles
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule : i2csl_tb_top

// ### pkg/i2csl_pkg.sv
/*
 * i2csl_pkg: register map, field positions, reset values and action codes
 * for the i2c slave interface block.
 * Assumes a single 200 MHz clock domain and a plain strobe register port.
 */
package i2csl_pkg;
	localparam int unsigned ADDR_W    = 4;
	localparam int unsigned DATA_W    = 32;
	// register offsets (4-bit select codes, one word each)
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_OWN_ADDR = 4'h4;
	localparam logic [3:0] REG_INT_EN   = 4'h8;
	localparam logic [3:0] REG_INT_RAW  = 4'hc;
	localparam logic [3:0] REG_INT_MSK  = 4'h6;
	localparam logic [3:0] REG_INT_CLR  = 4'h1;
	localparam logic [3:0] REG_STATUS   = 4'h2;
	localparam logic [3:0] REG_DATA     = 4'h3;
	// ctrl fields
	localparam int unsigned CTRL_ENABLE_BIT  = 0;
	localparam int unsigned CTRL_GLB_IE_BIT  = 1;
	localparam int unsigned CTRL_ALT_EN_BIT  = 2;
	localparam int unsigned CTRL_QCMD_EN_BIT = 3;
	// own address fields: primary [6:0], secondary [14:8]
	localparam int unsigned OWN0_LSB = 0;
	localparam int unsigned OWN1_LSB = 8;
	// interrupt bits
	localparam int unsigned INT_STOP_BIT  = 0;
	localparam int unsigned INT_START_BIT = 1;
	localparam int unsigned INT_DATA_BIT  = 2;
	localparam int unsigned INT_W         = 3;
	// status action codes
	localparam logic [6:0] act_idle              = 7'h00;
	localparam logic [6:0] act_master_wrote      = 7'h01;
	localparam logic [6:0] act_master_reads      = 7'h02;
	localparam logic [6:0] act_first_byte_in     = 7'h04;
	localparam logic [6:0] act_alt_address_hit   = 7'h08;
	localparam logic [6:0] act_quick_cmd         = 7'h10;
	localparam logic [6:0] act_quick_cmd_bit_set = 7'h20;
	// reset values and fifo size
	localparam logic [3:0]  CTRL_RST    = 4'h0;
	localparam logic [14:0] OWN_RST     = 15'h0000;
	localparam logic [2:0]  INT_EN_RST  = 3'h0;
	localparam logic [2:0]  INT_RAW_RST = 3'h0;
	localparam logic [7:0]  TX_BYTE_RST = 8'hff;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam int unsigned FIFO_WIDTH  = 8;
endpackage : i2csl_pkg

// ### src/i2csl_top.sv
/*
 * i2csl_top: slave end of an i2c controller with own-address matching,
 * action status, start/stop/data interrupt sources and a received-byte fifo.
 * Assumes scl/sda arrive asynchronously from the bus, open-drain outside.
 */
// Contract
// RQ1 - compare received address with own address
// RQ2 - load own address, then enable slave
// RQ3 - global enable gates combined interrupt
// RQ4 - clearing sources deasserts combined interrupt
// RQ5 - selective clear through bit mask
// RQ6 - per-source enable gates interrupt
// RQ7 - stop, start and data sources
// RQ8 - raw and masked status readable
// RQ9 - idle code when nothing requested
// RQ10 - receive code after master wrote
// RQ11 - transmit code when master reads
// RQ12 - first byte after address flagged
// RQ13 - secondary address match flagged
// RQ14 - quick command reported
// RQ15 - quick command data bit reported
// RQ16 - index zero primary, one secondary
// RQ17 - masked is raw AND enable
// RQ18 - raw bits sticky until cleared
module i2csl_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_q;
	logic [PW:0]      rd_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;
	// extra pointer bit tells full from empty
	assign in_ready  = (wr_q - rd_q) != (PW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[PW-1:0]];
	always_ff @(posedge clk) begin
		if (ce && push)
			mem[wr_q[PW-1:0]] <= in_data;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule : i2csl_fifo

module i2csl_top (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          ce,
	input  wire logic [i2csl_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [i2csl_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [i2csl_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe,
	output logic                               irq
);
	import i2csl_pkg::*;

	// one compare serves both own addresses
	function automatic logic addr_match(input logic [7:0] rx_byte, input logic [6:0] own);
		return rx_byte[7:1] == own;
	endfunction : addr_match

	// secondary-address flag joins every action code except idle
	function automatic logic [6:0] alt_code(input logic alt);
		return alt ? act_alt_address_hit : 7'h00;
	endfunction : alt_code

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_AACK = 6'b000100,
		ST_RX   = 6'b001000,
		ST_TX   = 6'b010000,
		ST_DACK = 6'b100000
	} i2csl_state_type;

	// three-stage sync; only stages 2 and 3 are looked at
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic       scl_q;
	logic       sda_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else if (ce) begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], sda_in};
			// a one-sample glitch never passes
			if (scl_s_q[1] == scl_s_q[2])
				scl_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_q <= sda_s_q[2];
		end
	end
	logic scl_d1_q;
	logic sda_d1_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else if (ce) begin
			scl_d1_q <= scl_q;
			sda_d1_q <= sda_q;
		end
	end
	wire scl_rise  = scl_q && !scl_d1_q;
	wire scl_fall  = !scl_q && scl_d1_q;
	// start and stop only count while scl stays high
	wire start_evt = scl_q && scl_d1_q && sda_d1_q && !sda_q;
	wire stop_evt  = scl_q && scl_d1_q && !sda_d1_q && sda_q;

	// software registers
	logic [3:0]       ctrl_q;
	logic [14:0]      own_q;
	logic [INT_W-1:0] int_en_q;
	logic [INT_W-1:0] int_raw_q;
	logic [7:0]       tx_byte_q;
	logic [6:0]       act_q;
	logic [6:0]       act_d;

	// RQ16 index zero primary
	wire [6:0] own0 = own_q[OWN0_LSB +: 7];
	wire [6:0] own1 = own_q[OWN1_LSB +: 7];
	wire       enabled = ctrl_q[CTRL_ENABLE_BIT];

	wire sel_ctrl = (reg_addr == REG_CTRL);
	wire sel_own  = (reg_addr == REG_OWN_ADDR);
	wire sel_ien  = (reg_addr == REG_INT_EN);
	wire sel_raw  = (reg_addr == REG_INT_RAW);
	wire sel_clr  = (reg_addr == REG_INT_CLR);
	wire sel_st   = (reg_addr == REG_STATUS);
	wire sel_dat  = (reg_addr == REG_DATA);
	wire sel_msk  = (reg_addr == REG_INT_MSK);

	// RQ17 masked equals raw and enables
	wire [INT_W-1:0] int_masked = int_raw_q & int_en_q;

	// bus-side fsm
	i2csl_state_type st_q;
	logic [3:0]      bit_q;
	logic [7:0]      sh_q;
	logic            first_q;
	logic            alt_q;
	logic            rw_q;
	logic            ack_q;
	logic            data_evt;
	logic            rx_push;
	logic            rx_ready;
	logic [7:0]      rx_out;
	logic            rx_valid;

	// RQ1 own address compare
	wire hit0 = addr_match(sh_q, own0);
	wire hit1 = ctrl_q[CTRL_ALT_EN_BIT] && addr_match(sh_q, own1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q    <= ST_IDLE;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			first_q <= 1'b0;
			alt_q   <= 1'b0;
			rw_q    <= 1'b0;
			ack_q   <= 1'b0;
		end else if (ce) begin
			// RQ2 inactive until enabled
			// a disable drops any frame in flight at once
			if (!enabled || stop_evt) begin
				st_q  <= ST_IDLE;
				ack_q <= 1'b0;
			end else if (start_evt) begin
				st_q  <= ST_ADDR;
				bit_q <= 4'h0;
				ack_q <= 1'b0;
			end else begin
				case (st_q)
					ST_ADDR: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda_q};
							bit_q <= bit_q + 4'h1;
						end else if (scl_fall && bit_q == 4'h8) begin
							if (hit0 || hit1) begin
								alt_q   <= !hit0;
								rw_q    <= sh_q[0];
								first_q <= 1'b1;
								ack_q   <= 1'b1;
								st_q    <= ST_AACK;
							end else
								st_q <= ST_IDLE;
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							ack_q <= rw_q ? ~tx_byte_q[7] : 1'b0;
							sh_q  <= {tx_byte_q[6:0], 1'b0};
							bit_q <= 4'h0;
							st_q  <= rw_q ? ST_TX : ST_RX;
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda_q};
							bit_q <= bit_q + 4'h1;
						end else if (scl_fall && bit_q == 4'h8) begin
							// full fifo: nack, the byte is dropped
							ack_q <= rx_ready;
							st_q  <= ST_DACK;
						end
					end
					ST_TX: begin
						if (scl_rise)
							bit_q <= bit_q + 4'h1;
						else if (scl_fall && bit_q == 4'h8) begin
							ack_q <= 1'b0;
							st_q  <= ST_DACK;
						end else if (scl_fall) begin
							ack_q <= ~sh_q[7];
							sh_q  <= {sh_q[6:0], 1'b0};
						end
					end
					ST_DACK: begin
						// master nack ends a read
						if (scl_rise && rw_q && sda_q)
							st_q <= ST_IDLE;
						else if (scl_fall) begin
							first_q <= rw_q ? first_q : 1'b0;
							ack_q   <= rw_q ? ~tx_byte_q[7] : 1'b0;
							sh_q    <= {tx_byte_q[6:0], 1'b0};
							bit_q   <= 4'h0;
							st_q    <= rw_q ? ST_TX : ST_RX;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// armed by an acked address, disarmed by the first finished byte
	logic qarm_q;
	always_ff @(posedge clk) begin
		if (sys_rst)
			qarm_q <= 1'b0;
		else if (ce) begin
			if (!enabled || stop_evt || start_evt || data_evt)
				qarm_q <= 1'b0;
			else if (st_q == ST_ADDR && scl_fall && bit_q == 4'h8 && (hit0 || hit1))
				qarm_q <= 1'b1;
		end
	end

	// one data event per completed byte
	assign data_evt = ce && scl_fall && bit_q == 4'h8 && (st_q == ST_RX || st_q == ST_TX);
	assign rx_push  = data_evt && st_q == ST_RX;
	// the ack clock has already moved the fsm on, so the stop lands in rx or tx;
	// the stop raises scl once more, hence at most one bit counted
	wire   qcmd_evt = ce && ctrl_q[CTRL_QCMD_EN_BIT] && stop_evt && qarm_q && bit_q <= 4'h1;

	// a data read pops; an empty fifo returns a stale byte
	i2csl_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.in_data  (sh_q),
		.in_valid (rx_push),
		.in_ready (rx_ready),
		.out_data (rx_out),
		.out_valid(rx_valid),
		.out_ready(ce && reg_rd && sel_dat)
	);

	// action status
	always_comb begin
		act_d = act_q;
		if (data_evt && st_q == ST_RX)
			// RQ10 RQ12 RQ13 receive codes
			act_d = act_master_wrote | (first_q ? act_first_byte_in : 7'h00) | alt_code(alt_q);
		else if (ce && st_q == ST_AACK && scl_fall && rw_q)
			// RQ11 RQ13 transmit request
			act_d = act_master_reads | alt_code(alt_q);
		else if (qcmd_evt)
			// RQ14 RQ15 quick command
			act_d = act_quick_cmd | (rw_q ? act_quick_cmd_bit_set : 7'h00) | alt_code(alt_q);
		else if (ce && reg_rd && sel_st && !rx_valid)
			// RQ9 idle once serviced
			act_d = act_idle;
	end

	wire [INT_W-1:0] evt_bits = {data_evt || qcmd_evt, ce && start_evt && enabled, ce && stop_evt && enabled};
	wire [INT_W-1:0] clr_bits = (ce && reg_wr && sel_clr) ? reg_wdata[INT_W-1:0] : '0;
	// next raw value; irq is built from it so both move on one edge
	wire [INT_W-1:0] raw_d    = (int_raw_q & ~clr_bits) | evt_bits;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q    <= CTRL_RST;
			own_q     <= OWN_RST;
			int_en_q  <= INT_EN_RST;
			int_raw_q <= INT_RAW_RST;
			tx_byte_q <= TX_BYTE_RST;
			act_q     <= act_idle;
		end else if (ce) begin
			if (reg_wr && sel_ctrl)
				ctrl_q <= reg_wdata[3:0];
			// gap bit kept zero between the two fields
			if (reg_wr && sel_own)
				own_q <= {reg_wdata[OWN1_LSB +: 7], 1'b0, reg_wdata[OWN0_LSB +: 7]};
			// RQ6 per-source enables
			if (reg_wr && sel_ien)
				int_en_q <= reg_wdata[INT_W-1:0];
			// one tx byte: a burst read repeats it unless refilled
			if (reg_wr && sel_dat)
				tx_byte_q <= reg_wdata[7:0];
			// RQ5 RQ18 RQ7 sticky, set beats clear
			int_raw_q <= raw_d;
			act_q     <= act_d;
		end
	end

	// RQ8 raw and masked readback
	wire [DATA_W-1:0] rd_mux =
		sel_ctrl ? DATA_W'(ctrl_q) :
		sel_own  ? DATA_W'(own_q) :
		sel_ien  ? DATA_W'(int_en_q) :
		sel_raw  ? DATA_W'(int_raw_q) :
		sel_msk  ? DATA_W'(int_masked) :
		sel_st   ? DATA_W'(act_q) :
		sel_dat  ? DATA_W'(rx_out) : '0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
			irq       <= 1'b0;
			sda_out   <= 1'b0;
			sda_oe    <= 1'b0;
		end else if (ce) begin
			// zero outside reads keeps an or-ed read bus clean
			reg_rdata <= reg_rd ? rd_mux : '0;
			// RQ3 RQ4 global gate, clear drops line
			irq       <= ctrl_q[CTRL_GLB_IE_BIT] && |(raw_d & int_en_q);
			sda_out   <= 1'b0;
			// release at a stop so the bus frees at once
			sda_oe    <= ack_q && enabled && !stop_evt;
		end
	end
endmodule : i2csl_top
